// File: hw/pms_power_mode_sequencer.sv
// Power mode sequencer: resource timers, mode machine, AXI4-Lite registers
module pms_power_mode_sequencer (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [pms_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output      logic                      awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output      logic                      wready,
  output      logic [1:0]                bresp,
  output      logic                      bvalid,
  input  wire logic                      bready,
  input  wire logic [pms_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output      logic                      arready,
  output      logic [31:0]               rdata,
  output      logic [1:0]                rresp,
  output      logic                      rvalid,
  input  wire logic                      rready,
  input  wire logic                      reg_on_pin,
  input  wire logic                      lpo_clk_pin,
  input  wire logic                      wake_ext_pin,
  input  wire logic                      usb_resume_pin,
  input  wire logic [3:0]                clk_req,
  input  wire logic                      retain_done,
  output      logic [pms_pkg::NRES-1:0]  res_pwr,
  output      pms_pkg::pms_clk_t         clk_ctl,
  output      pms_pkg::pms_mode_t        mode,
  output      logic                      retain_save,
  output      logic                      retain_restore,
  output      logic                      core_rst_n
);
  import pms_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [NRES-1:0] close_deps(input logic [NRES-1:0] r0,
                                                 input logic [NRES*NRES-1:0] d);
    logic [NRES-1:0] r;
    r = r0;
    for (int k = 0; k < NRES; k++)
      for (int i = 0; i < NRES; i++)
        if (r[i])
          r = r | d[NRES*i +: NRES];
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        m[8*b +: 8] = n[8*b +: 8];
    return m;
  endfunction

  // ****************************************
  // Pin synchronisers and low-power tick
  // ****************************************
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic       lpo_d_reg;
  wire        reg_on_s  = pin_s2_reg[0];
  wire        lpo_tick  = pin_s2_reg[1] && !lpo_d_reg;
  wire        wake_pins = pin_s2_reg[2] || pin_s2_reg[3];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      lpo_d_reg  <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {usb_resume_pin, wake_ext_pin, lpo_clk_pin, reg_on_pin};
      pin_s2_reg <= pin_s1_reg;
      lpo_d_reg  <= pin_s2_reg[1];
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  pms_mode_t          mode_reg, mode_next;
  logic [1:0]         tgt_reg;
  logic [NRES-1:0]    minres_reg;
  logic [31:0]        dep_lo_reg, dep_hi_reg, clkmap_reg;
  logic [TMR_W-1:0]   reqtmr_reg, waketmr_reg;
  logic [NRES-1:0]    reqmask_reg;
  logic [31:0]        time_mem [NRES];
  logic [31:0]        cal_reg, cal_cyc_reg, lpo_cnt_reg;
  logic [4:0]         cal_tick_reg;
  logic [NRES-1:0]    state_reg, pend_reg;
  logic [TMR_W-1:0]   tmr_reg [NRES];

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic              aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg, rdata_reg;
  logic [3:0]        wstrb_reg;
  logic [1:0]        bresp_reg, rresp_reg;

  assign awready = !aw_hold_reg && !bvalid_reg;
  assign wready  = !w_hold_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  wire              aw_take = awvalid && awready;
  wire              w_take  = wvalid && wready;
  wire              wr_fire = (aw_hold_reg || aw_take) && (w_hold_reg || w_take);
  wire [ADDR_W-1:0] wa      = aw_hold_reg ? awaddr_reg : awaddr;
  wire [31:0]       wd      = w_hold_reg ? wdata_reg : wdata;
  wire [3:0]        ws      = w_hold_reg ? wstrb_reg : wstrb;
  wire [ADDR_W-1:0] wa_w    = {wa[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ra_w    = {araddr[ADDR_W-1:2], 2'b00};
  wire              wr_time = wa[ADDR_W-1:5] == TIME_PAGE;
  wire              rd_time = araddr[ADDR_W-1:5] == TIME_PAGE;
  wire              wr_ok   = wr_time || (wa_w <= OFF_WAKETMR);
  wire              rd_ok   = rd_time || (ra_w <= OFF_LPOCNT);
  wire [31:0]       rd_word =
    rd_time              ? time_mem[araddr[4:2]] :
    ra_w == OFF_CTRL     ? {30'h0, tgt_reg} :
    ra_w == OFF_MINRES   ? {24'h0, minres_reg} :
    ra_w == OFF_DEP_LO   ? dep_lo_reg :
    ra_w == OFF_DEP_HI   ? dep_hi_reg :
    ra_w == OFF_CLKMAP   ? clkmap_reg :
    ra_w == OFF_REQTMR   ? {8'h0, reqmask_reg, reqtmr_reg} :
    ra_w == OFF_WAKETMR  ? {16'h0, waketmr_reg} :
    ra_w == OFF_STATUS   ? {9'h0, mode_reg, pend_reg, state_reg} :
    ra_w == OFF_CAL      ? cal_reg :
    ra_w == OFF_LPOCNT   ? lpo_cnt_reg : 32'h0;
  wire              do_wr   = wr_fire && wr_ok;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (aw_take)
        awaddr_reg <= awaddr;
      if (w_take)
      begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      aw_hold_reg <= (aw_hold_reg || aw_take) && !wr_fire;
      w_hold_reg  <= (w_hold_reg || w_take) && !wr_fire;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_ok ? rd_word : 32'h0;
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid_reg <= 1'b0;
  end

  // ****************************************
  // Mode machine
  // ****************************************
  wire             in_sleep  = mode_reg == M_DOZE || mode_reg == M_DEEP;
  wire             wake_tmr  = in_sleep && lpo_tick && waketmr_reg == 16'h1;
  wire             wake      = wake_pins || wake_tmr;
  wire [NRES-1:0]  en_res    = state_reg & ~pend_reg;
  wire             boot_up   = (en_res & BOOT_SET) == BOOT_SET;
  wire             core_up   = (en_res & ACTIVE_SET) == ACTIVE_SET;
  wire             to_active = mode_next == M_ACTIVE && mode_reg != M_ACTIVE;

  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      M_OFF:     mode_next = M_BOOT;
      M_BOOT:    if (boot_up) mode_next = M_ACTIVE;
      M_ACTIVE:  if (tgt_reg == TGT_DOZE) mode_next = M_DOZE;
                 else if (tgt_reg == TGT_DEEP) mode_next = M_SAVE;
      M_DOZE:    if (wake) mode_next = M_ACTIVE;
      M_SAVE:    if (retain_done) mode_next = M_DEEP;
      M_DEEP:    if (wake) mode_next = M_RESTORE;
      M_RESTORE: if (retain_done && retain_restore) mode_next = M_ACTIVE;
      default:   mode_next = M_OFF;
    endcase
    if (!reg_on_s)
      mode_next = M_OFF;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= M_OFF;
    else
      mode_reg <= mode_next;
  end

  // ****************************************
  // Software registers and timers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tgt_reg     <= TGT_ACTIVE;
      minres_reg  <= MINRES_RST;
      dep_lo_reg  <= DEP_LO_RST;
      dep_hi_reg  <= DEP_HI_RST;
      clkmap_reg  <= CLKMAP_RST;
      reqtmr_reg  <= '0;
      reqmask_reg <= '0;
      waketmr_reg <= '0;
      for (int i = 0; i < NRES; i++)
        time_mem[i] <= TIME_RST;
    end
    else
    begin
      if (lpo_tick && reqtmr_reg != 0)
        reqtmr_reg <= reqtmr_reg - 16'h1;
      if (lpo_tick && in_sleep && waketmr_reg != 0)
        waketmr_reg <= waketmr_reg - 16'h1;
      if (to_active)
        tgt_reg <= TGT_ACTIVE;
      if (do_wr)
      begin
        if (wr_time)
          time_mem[wa[4:2]] <= merge(time_mem[wa[4:2]], wd, ws);
        else if (wa_w == OFF_CTRL && ws[0])
          tgt_reg <= wd[1:0];
        else if (wa_w == OFF_MINRES && ws[0])
          minres_reg <= wd[NRES-1:0];
        else if (wa_w == OFF_DEP_LO)
          dep_lo_reg <= merge(dep_lo_reg, wd, ws);
        else if (wa_w == OFF_DEP_HI)
          dep_hi_reg <= merge(dep_hi_reg, wd, ws);
        else if (wa_w == OFF_CLKMAP)
          clkmap_reg <= merge(clkmap_reg, wd, ws);
        else if (wa_w == OFF_REQTMR)
        begin
          reqtmr_reg  <= wd[TMR_W-1:0];
          reqmask_reg <= wd[TMR_W +: NRES];
        end
        else if (wa_w == OFF_WAKETMR)
          waketmr_reg <= wd[TMR_W-1:0];
      end
    end
  end

  // Crystal-side cycle count over a fixed number of slow ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cal_reg      <= CAL_NOMINAL;
      cal_cyc_reg  <= 32'h0;
      cal_tick_reg <= 5'h0;
      lpo_cnt_reg  <= 32'h0;
    end
    else
    begin
      cal_cyc_reg <= cal_cyc_reg + 32'h1;
      if (lpo_tick)
      begin
        lpo_cnt_reg  <= lpo_cnt_reg + 32'h1;
        cal_tick_reg <= cal_tick_reg + 5'h1;
        if (cal_tick_reg == 5'(CAL_TICKS - 1))
        begin
          cal_reg     <= cal_cyc_reg + 32'h1;
          cal_cyc_reg <= 32'h0;
        end
      end
    end
  end

  // ****************************************
  // Resource request and sequencing
  // ****************************************
  wire [NRES*NRES-1:0] dep_all = {dep_hi_reg, dep_lo_reg};
  wire [NRES-1:0] clk_need =
    (clk_req[0] ? clkmap_reg[7:0] : 8'h0) | (clk_req[1] ? clkmap_reg[15:8] : 8'h0) |
    (clk_req[2] ? clkmap_reg[23:16] : 8'h0) | (clk_req[3] ? clkmap_reg[31:24] : 8'h0);
  wire [NRES-1:0] treq     = reqtmr_reg != 0 ? reqmask_reg : 8'h0;
  wire [NRES-1:0] act_req  = ACTIVE_SET | minres_reg | clk_need | treq;
  wire [NRES-1:0] base_req =
    mode_reg == M_BOOT   ? BOOT_SET :
    mode_reg == M_ACTIVE ? act_req :
    mode_reg == M_DOZE   ? DOZE_SET :
    mode_reg == M_DEEP   ? DEEP_SET :
    (mode_reg == M_SAVE || mode_reg == M_RESTORE) ? (ACTIVE_SET | DEEP_SET) : 8'h0;
  wire [NRES-1:0] need     = close_deps(base_req, dep_all) & (in_sleep ? ~LOWCON_OFF : 8'hff);

  logic [NRES-1:0]  dpnd, start_on, start_off;
  logic [TMR_W-1:0] ld_t [NRES];

  always_comb
  begin
    for (int i = 0; i < NRES; i++)
    begin
      dpnd[i] = 1'b0;
      for (int j = 0; j < NRES; j++)
        dpnd[i] = dpnd[i] | ((state_reg[j] | pend_reg[j]) & dep_all[NRES*j + i]);
      start_on[i]  = tmr_reg[i] == 0 && !state_reg[i] && need[i] &&
                     (dep_all[NRES*i +: NRES] & ~en_res) == 0;
      start_off[i] = tmr_reg[i] == 0 && state_reg[i] && !need[i] && !dpnd[i];
      ld_t[i]      = start_on[i] ? time_mem[i][15:0] : time_mem[i][31:16];
    end
  end

  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < NRES; i++)
    begin
      if (!aresetn || !reg_on_s)
      begin
        state_reg[i] <= 1'b0;
        pend_reg[i]  <= 1'b0;
        tmr_reg[i]   <= '0;
      end
      else if (tmr_reg[i] != 0)
      begin
        if (lpo_tick)
        begin
          tmr_reg[i] <= tmr_reg[i] - 16'h1;
          if (tmr_reg[i] == 16'h1)
          begin
            pend_reg[i]  <= 1'b0;
            state_reg[i] <= !state_reg[i];
          end
        end
      end
      else if (start_on[i] || start_off[i])
      begin
        if (ld_t[i] == 0)
          state_reg[i] <= !state_reg[i];
        else
        begin
          tmr_reg[i]  <= ld_t[i];
          pend_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  pms_clk_t clk_ctl_reg;
  logic     restore_reg, core_rst_n_reg;
  wire      clk_mode = mode_reg == M_ACTIVE || mode_reg == M_BOOT ||
                       mode_reg == M_SAVE || mode_reg == M_RESTORE;

  // Enable leads done by the on-time so a regulator can settle
  assign res_pwr        = state_reg ^ pend_reg;
  assign clk_ctl        = clk_ctl_reg;
  assign mode           = mode_reg;
  assign retain_save    = mode_reg == M_SAVE;
  assign retain_restore = restore_reg;
  assign core_rst_n     = core_rst_n_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_ctl_reg    <= '0;
      restore_reg    <= 1'b0;
      core_rst_n_reg <= 1'b0;
    end
    else
    begin
      clk_ctl_reg.main_clk_en  <= clk_mode && en_res[RES_XTAL];
      clk_ctl_reg.core_clk_en  <= clk_mode && en_res[RES_XTAL] && en_res[RES_DIGITAL];
      clk_ctl_reg.slow_clk_sel <= clk_req == 4'h0;
      restore_reg              <= mode_reg == M_RESTORE && core_up && !retain_done;
      core_rst_n_reg           <= reg_on_s && boot_up;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_saving;
    mode_reg == M_SAVE && retain_done;
  endsequence
  sequence s_in_deep;
    mode_reg == M_DEEP;
  endsequence

  chk_all_off_low: assert property (!reg_on_s |=> res_pwr == 8'h0 && mode_reg == M_OFF)
    else $error("Resources left powered with enable low");
  chk_boot_on_rise: assert property ($rose(reg_on_s) ##1 reg_on_s |-> mode_reg == M_BOOT)
    else $error("Boot did not follow enable rise");
  chk_lowcon_need: assert property (in_sleep |=> (res_pwr & ~$past(res_pwr) & LOWCON_OFF) == 8'h0)
    else $error("Core regulator turned on in low mode");
  chk_timer_load: assert property (reg_on_s && start_on[0] && ld_t[0] != 0 ##1 reg_on_s
                                   |-> pend_reg[0] && tmr_reg[0] == $past(ld_t[0]))
    else $error("Turn-on time not loaded");
  chk_timer_done: assert property (reg_on_s && tmr_reg[0] == 16'h1 && lpo_tick ##1 reg_on_s
                                   |-> !pend_reg[0] && state_reg[0] != $past(state_reg[0]))
    else $error("Transition did not finish at zero");
  chk_deps_held: assert property (reg_on_s && en_res[RES_RADIO] && $stable(dep_all)
                                  |-> (dep_all[NRES*RES_RADIO +: NRES] & ~state_reg) == 8'h0)
    else $error("Radio enabled without dependencies");
  chk_save_first: assert property (s_saving ##1 reg_on_s |-> s_in_deep)
    else $error("Deep sleep not entered after save");
  chk_deep_entry: assert property ($rose(mode_reg == M_DEEP) |-> $past(mode_reg) == M_SAVE)
    else $error("Deep sleep entered without save");
  chk_wake_restore: assert property (s_in_deep and wake && reg_on_s |=> mode_reg == M_RESTORE)
    else $error("Wake from deep sleep skipped restore");
  chk_doze_clocks: assert property (mode_reg == M_DOZE [*2] |-> !clk_ctl.main_clk_en)
    else $error("Main clock running in doze");

endmodule : pms_power_mode_sequencer

// File: hw/pms_pkg.sv
// Shared constants, types and register map of the power mode sequencer
package pms_pkg;

  // ****************************************
  // Sizes and resource indices
  // ****************************************
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NRES     = 8;
  localparam int unsigned TMR_W    = 16;
  localparam int unsigned RES_CORE_BUCK  = 0;
  localparam int unsigned RES_CORE_LIN   = 1;
  localparam int unsigned RES_LOW_NOISE  = 2;
  localparam int unsigned RES_LOW_POWER  = 3;
  localparam int unsigned RES_RADIO      = 4;
  localparam int unsigned RES_XTAL       = 5;
  localparam int unsigned RES_DIGITAL    = 6;
  localparam int unsigned RES_RETENTION  = 7;

  // ****************************************
  // Resource sets per mode
  // ****************************************
  localparam logic [NRES-1:0] BOOT_SET   = 8'h0f;
  localparam logic [NRES-1:0] ACTIVE_SET = 8'h57;
  localparam logic [NRES-1:0] DOZE_SET   = 8'hc8;
  localparam logic [NRES-1:0] DEEP_SET   = 8'h88;
  localparam logic [NRES-1:0] LOWCON_OFF = 8'h07;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MINRES  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DEP_LO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DEP_HI  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CLKMAP  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_REQTMR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_WAKETMR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_CAL     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_LPOCNT  = 8'h24;
  localparam logic [2:0]        TIME_PAGE   = 3'h2;
  localparam logic [NRES-1:0]   MINRES_RST  = 8'h08;
  localparam logic [31:0]       DEP_LO_RST  = 32'h0001_0100;
  localparam logic [31:0]       DEP_HI_RST  = 32'h0808_0224;
  localparam logic [31:0]       CLKMAP_RST  = 32'h3030_2020;
  localparam logic [31:0]       TIME_RST    = 32'h0001_0004;
  localparam logic [1:0]        TGT_ACTIVE  = 2'h0;
  localparam logic [1:0]        TGT_DOZE    = 2'h1;
  localparam logic [1:0]        TGT_DEEP    = 2'h2;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // ****************************************
  // Clock rates and calibration
  // ****************************************
  localparam longint unsigned CLK_HZ    = 20_000_000;
  localparam longint unsigned LPO_HZ    = 32_768;
  localparam int unsigned     CAL_TICKS = 32;
  localparam logic [31:0]     CAL_NOMINAL = 32'(CLK_HZ * CAL_TICKS / LPO_HZ);

  typedef enum logic [6:0] {
    M_OFF     = 7'h01,
    M_BOOT    = 7'h02,
    M_ACTIVE  = 7'h04,
    M_DOZE    = 7'h08,
    M_SAVE    = 7'h10,
    M_DEEP    = 7'h20,
    M_RESTORE = 7'h40
  } pms_mode_t;

  typedef struct packed {
    logic main_clk_en;
    logic core_clk_en;
    logic slow_clk_sel;
  } pms_clk_t;

endpackage : pms_pkg

// File: bench/pms_host_model.sv
// Host-side model: regulator enable pin and free-running low-power clock
module pms_host_model (
  input  wire logic power_on,
  output      logic reg_on_pin,
  output      logic lpo_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_on_pin = 1'h0;
  initial lpo_clk_pin = 1'h0;
  // Host pin moves off the bus clock edge, like a separate device would
  always @(power_on) reg_on_pin <= #7 power_on;
  // Oscillator never stops, so ticks keep coming in every mode
  always #15259 lpo_clk_pin = ~lpo_clk_pin;
endmodule // pms_host_model

// File: bench/test_pms_power_mode_sequencer.sv
// Testbench for the power mode sequencer over its register bus
module test_pms_power_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import pms_pkg::*;
  logic             aclk = 1'h0, aresetn = 1'h0, power_on = 1'h0, retain_done = 1'h0;
  logic             awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic             wake_ext_pin = 1'h0, usb_resume_pin = 1'h0;
  logic [7:0]       awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]      wdata = 32'h0;
  logic [3:0]       wstrb = 4'h0, clk_req = 4'h0;
  logic             awready, wready, bvalid, arready, rvalid, reg_on_pin, lpo_clk_pin;
  logic             retain_save, retain_restore, core_rst_n;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  logic [NRES-1:0]  res_pwr;
  pms_clk_t         clk_ctl;
  pms_mode_t        mode;
  int               num_errors = 0, comparisons = 0;

  pms_power_mode_sequencer pms_power_mode_sequencer_i (.*);
  pms_host_model pms_host_model_i (.*);

  always #25 aclk = ~aclk;

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(nm, rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // Bounded: a stuck machine shows up as a mode mismatch
  task automatic wait_mode(input pms_mode_t m);
    for (int n = 0; n < 5000 && mode !== m; n++) @(posedge aclk);
    chk("mode", 32'(mode), 32'(m));
  endtask

  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFF_MINRES, "minres", 32'(MINRES_RST), RESP_OKAY);
    rd(OFF_DEP_LO, "dep_lo", DEP_LO_RST, RESP_OKAY);
    rd(OFF_DEP_HI, "dep_hi", DEP_HI_RST, RESP_OKAY);
    rd(OFF_CLKMAP, "clkmap", CLKMAP_RST, RESP_OKAY);
    rd(8'h40, "time0", TIME_RST, RESP_OKAY);
    rd(OFF_CAL, "cal", CAL_NOMINAL, RESP_OKAY);
    rd(8'h30, "unmapped", 32'h0, RESP_SLVERR);
    wr(OFF_STATUS, 32'h0, RESP_SLVERR);
    chk("mode_off", 32'(mode), 32'(M_OFF));
    chk("pwr_off", 32'(res_pwr), 32'h0);
    for (int i = 0; i < NRES; i++) wr(8'(8'h40 + 4 * i), 32'h0, RESP_OKAY);
    rd(8'h5c, "time7", 32'h0, RESP_OKAY);
    // Core buck keeps a one-tick on and off time so the timer path runs
    wr(8'h40, 32'h0001_0001, RESP_OKAY);
    power_on <= 1'h1;
    wait_mode(M_ACTIVE);
    chk("boot_set", 32'(res_pwr & BOOT_SET), 32'(BOOT_SET));
    chk("core_rst", 32'(core_rst_n), 32'h1);
    wr(OFF_REQTMR, 32'h0080_0002, RESP_OKAY);
    clk_req <= 4'h1;
    repeat (3) @(posedge aclk);
    chk("timer_req", 32'(res_pwr[RES_RETENTION]), 32'h1);
    chk("slow_clk", 32'(clk_ctl.slow_clk_sel), 32'h0);
    chk("core_clk", 32'(clk_ctl.core_clk_en), 32'h1);
    for (int n = 0; n < 5000 && res_pwr[RES_RETENTION] !== 1'h0; n++) @(posedge aclk);
    chk("timer_end", 32'(res_pwr[RES_RETENTION]), 32'h0);
    clk_req <= 4'h0;
    wr(OFF_CTRL, 32'(TGT_DOZE), RESP_OKAY);
    wait_mode(M_DOZE);
    for (int n = 0; n < 5000 && (res_pwr & LOWCON_OFF) !== 8'h0; n++) @(posedge aclk);
    chk("doze_pwr", 32'(res_pwr & 8'h1f), 32'h8);
    chk("doze_clk", 32'(clk_ctl.main_clk_en), 32'h0);
    wake_ext_pin <= 1'h1;
    wait_mode(M_ACTIVE);
    wake_ext_pin <= 1'h0;
    rd(OFF_CTRL, "ctrl", 32'(TGT_ACTIVE), RESP_OKAY);
    wr(OFF_WAKETMR, 32'h2, RESP_OKAY);
    wr(OFF_CTRL, 32'(TGT_DOZE), RESP_OKAY);
    wait_mode(M_DOZE);
    wait_mode(M_ACTIVE);
    wr(OFF_CTRL, 32'(TGT_DEEP), RESP_OKAY);
    wait_mode(M_SAVE);
    chk("save", 32'(retain_save), 32'h1);
    retain_done <= 1'h1;
    wait_mode(M_DEEP);
    retain_done <= 1'h0;
    for (int n = 0; n < 5000 && (res_pwr & LOWCON_OFF) !== 8'h0; n++) @(posedge aclk);
    chk("deep_pwr", 32'(res_pwr & LOWCON_OFF), 32'h0);
    usb_resume_pin <= 1'h1;
    wait_mode(M_RESTORE);
    usb_resume_pin <= 1'h0;
    for (int n = 0; n < 5000 && retain_restore !== 1'h1; n++) @(posedge aclk);
    chk("restore", 32'(retain_restore), 32'h1);
    retain_done <= 1'h1;
    wait_mode(M_ACTIVE);
    retain_done <= 1'h0;
    power_on <= 1'h0;
    wait_mode(M_OFF);
    chk("down_pwr", 32'(res_pwr), 32'h0);
    chk("down_rst", 32'(core_rst_n), 32'h0);
    power_on <= 1'h1;
    wait_mode(M_ACTIVE);
    give_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
endmodule // test_pms_power_mode_sequencer
